/* File: core/irq_unit_regs.svh */
// Register offsets, field positions, reset values and vector constants of the interrupt unit.
// Assumes inclusion by bare name from design files that need the map.
`ifndef IRQ_UNIT_REGS_SVH
`define IRQ_UNIT_REGS_SVH

// Register indices; the bus byte address is four times the index
`define PRIO_IDX        8'hf9
`define REQ_IDX         8'hfa
`define MASK_IDX        8'hfb
`define STAT_IDX        8'hfc
`define IMASK_IDX       8'hfd
`define CPU_IDX         8'hfe
`define ADDR_OF(idx)    ({22'h0, (idx), 2'b00})

// Field positions and source count
`define MASK_GLOBAL_BIT 7
`define NUM_SRC         6

// Reset values
`define PRIO_RST        8'h00
`define REQ_RST         8'h00
`define MASK_RST        8'h00
`define IMASK_RST       8'h00

// Vector table: slot n occupies bytes 2n and 2n+1 of program memory
`define VEC_STRIDE      16'h0002

`endif

/* File: core/irq_unit_pkg.sv */
// Types of the interrupt unit.
// Assumes the register header is included where constants are needed.
`default_nettype none
package irq_unit_pkg;

    // Grant sequencer states
    typedef enum logic [2:0] {
        GS_IDLE  = 3'b000,
        GS_PUSH  = 3'b001,
        GS_VLO   = 3'b010,
        GS_VHI   = 3'b011,
        GS_DONE  = 3'b100
    } grant_state_e;

    typedef logic [5:0] src_vec_t;

endpackage : irq_unit_pkg

`default_nettype wire

/* File: core/irq_edge_detect.sv */
// Edge detectors for the three falling-edge pins, the shared rising-edge pin and timers.
// Assumes inputs are synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none

module irq_edge_detect (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    // Pins and timers
    input  wire logic       port3_pin1_i,
    input  wire logic       port3_pin2_i,
    input  wire logic       port3_pin3_i,
    input  wire logic       counter_timer_zero_i,
    input  wire logic       counter_timer_one_i,
    // One-cycle request pulses in source order
    output logic      [5:0] edge_pulse_o
);
    logic [2:0] pin_q;      // Previous pin levels

    // Remember last pin levels; pins idle high after reset
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_q <= 3'b111;
        end else begin
            pin_q <= {port3_pin3_i, port3_pin2_i, port3_pin1_i};
        end
    end

    assign edge_pulse_o[0] = pin_q[1] & ~port3_pin2_i;   // Falling shared pin
    assign edge_pulse_o[1] = pin_q[2] & ~port3_pin3_i;   // Falling reference pin
    assign edge_pulse_o[2] = pin_q[0] & ~port3_pin1_i;   // Falling first pin
    assign edge_pulse_o[3] = ~pin_q[1] & port3_pin2_i;   // Rising shared pin
    assign edge_pulse_o[4] = counter_timer_zero_i;        // Timer 0 terminal event
    assign edge_pulse_o[5] = counter_timer_one_i;         // Timer 1 terminal event

endmodule : irq_edge_detect

`default_nettype wire

/* File: core/irq_prio_encoder.sv */
// Programmable priority encoder over six pending sources.
// Assumes the priority byte comes from a register; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module irq_prio_encoder (
    // Inputs
    input  wire logic [5:0] pend_i,
    input  wire logic [7:0] prio_i,
    // Result
    output logic            any_o,
    output logic      [2:0] idx_o
);
    // Rank order: prio_i[2:0] rotates the start index, prio_i[3] reverses direction
    function automatic logic [2:0] rank_to_src(input logic [2:0] r, input logic [7:0] p);
        logic [3:0] s;
        s = 4'h0;
        if (p[3]) begin
            s = {1'b0, p[2:0]} + 4'd6 - {1'b0, r};
        end else begin
            s = {1'b0, p[2:0]} + {1'b0, r};
        end
        if (s >= 4'd12) begin
            s = s - 4'd12;
        end else if (s >= 4'd6) begin
            s = s - 4'd6;
        end
        return s[2:0];
    endfunction : rank_to_src

    logic [5:0] hit;    // Pending source at rank n
    logic [5:0] first;  // One-hot first hit

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_rank
            assign hit[g] = pend_i[rank_to_src(3'(g), prio_i)];
        end
    endgenerate

    assign first = hit & ~(hit - 6'd1);   // Highest-ranked pending
    assign any_o = |hit;
    assign idx_o = rank_to_src(first[0] ? 3'd0 : first[1] ? 3'd1 : first[2] ? 3'd2 :
                               first[3] ? 3'd3 : first[4] ? 3'd4 : 3'd5, prio_i);

endmodule : irq_prio_encoder

`default_nettype wire

/* File: core/irq_unit.sv */
// Six-source vectored interrupt unit with AHB-Lite register slave.
// Assumes one clock, synchronous pins and a single-word AHB-Lite master.
// Behaviour
// - Six sources, each maskable and prioritised
// - Falling edges on three pins request
// - Rising edge on shared pin requests
// - Two timers raise internal requests
// - Two-byte vector slots 0..5, one per source
// - Mask has global and per-source enables
// - Programmable priority encoder picks winner
// - Grant disables, pushes PC/flags, vectors
// - Two vector bytes form 16-bit address
// - Masked requests still recorded for polling
// - Halt wakes on enabled request
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_regs.svh"

module irq_unit (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Sources
    input  wire logic        port3_pin1_i,
    input  wire logic        port3_pin2_i,
    input  wire logic        port3_pin3_i,
    input  wire logic        counter_timer_zero_i,
    input  wire logic        counter_timer_one_i,
    // Core handshake
    input  wire logic        int_cycle_i,
    input  wire logic [15:0] pc_i,
    input  wire logic [7:0]  flags_i,
    input  wire logic        halted_i,
    input  wire logic [7:0]  pmem_data_i,
    output logic             int_pending_o,
    output logic             wake_o,
    output logic      [15:0] pmem_addr_o,
    output logic             pmem_rd_o,
    output logic             push_o,
    output logic      [23:0] push_data_o,
    output logic             pc_load_o,
    output logic      [15:0] pc_value_o,
    output logic             gie_clr_o,
    // Unit status interrupt
    output logic             irq_o
);
    // Bus address-phase capture
    logic        ap_valid_q;     // Data phase pending
    logic        ap_write_q;     // Pending is a write
    logic [7:0]  ap_idx_q;       // Register index of pending access

    // Software registers
    logic [7:0]  prio_q;         // Priority programming
    logic [7:0]  mask_q;         // Global bit 7 and per-source bits
    logic [5:0]  req_q;          // Pending requests
    logic [5:0]  stat_q;         // Sticky grant events
    logic [5:0]  imask_q;        // Mask for irq_o

    // Grant sequencer
    irq_unit_pkg::grant_state_e gs_q;
    irq_unit_pkg::grant_state_e gs_d;
    logic [2:0]  win_q;          // Latched winning source
    logic [7:0]  vlo_q;          // High vector byte captured first

    // Registered outputs
    logic [31:0] hrdata_q;
    logic        pend_q;
    logic        wake_q;
    logic [15:0] paddr_q;
    logic        prd_q;
    logic        push_q;
    logic [23:0] pdata_q;
    logic        pcl_q;
    logic [15:0] pcv_q;
    logic        gie_q;
    logic        irq_q;

    // Edge pulses and encoder results
    logic [5:0]  edge_pulse;
    logic        any_en;
    logic [2:0]  win_idx;

    irq_edge_detect u_edge (
        .clk_sys_i            (clk_sys_i),
        .sys_rst_i            (sys_rst_i),
        .port3_pin1_i         (port3_pin1_i),
        .port3_pin2_i         (port3_pin2_i),
        .port3_pin3_i         (port3_pin3_i),
        .counter_timer_zero_i (counter_timer_zero_i),
        .counter_timer_one_i  (counter_timer_one_i),
        .edge_pulse_o         (edge_pulse)
    );

    // Enabled pending set: global bit and own bit both needed
    wire [5:0] enabled = req_q & mask_q[5:0] & {6{mask_q[`MASK_GLOBAL_BIT]}};

    irq_prio_encoder u_prio (
        .pend_i (enabled),
        .prio_i (prio_q),
        .any_o  (any_en),
        .idx_o  (win_idx)
    );

    // Bus decode
    wire       ap_take  = hsel_i & hready_i & htrans_i[1];
    wire       wr_now   = ap_valid_q & ap_write_q;
    wire       rd_now   = ap_valid_q & ~ap_write_q;
    wire       wr_prio  = wr_now & (ap_idx_q == `PRIO_IDX);
    wire       wr_req   = wr_now & (ap_idx_q == `REQ_IDX);
    wire       wr_mask  = wr_now & (ap_idx_q == `MASK_IDX);
    wire       wr_imask = wr_now & (ap_idx_q == `IMASK_IDX);
    wire       rd_stat  = ap_take & ~hwrite_i & (haddr_i[9:2] == `STAT_IDX);

    // Read mux, returned in the data phase
    wire [7:0] rd_byte  =
        (haddr_i[9:2] == `PRIO_IDX)  ? prio_q :
        (haddr_i[9:2] == `REQ_IDX)   ? {2'b00, req_q} :
        (haddr_i[9:2] == `MASK_IDX)  ? mask_q :
        (haddr_i[9:2] == `STAT_IDX)  ? {2'b00, stat_q} :
        (haddr_i[9:2] == `IMASK_IDX) ? {2'b00, imask_q} :
        (haddr_i[9:2] == `CPU_IDX)   ? {4'h0, gs_q != irq_unit_pkg::GS_IDLE, win_q} :
        8'h00;
    wire       unmapped = haddr_i[31:10] != 22'h0;

    // Grant start: core opens interrupt cycle with something enabled
    wire       grant_go = (gs_q == irq_unit_pkg::GS_IDLE) & int_cycle_i & any_en;
    wire [5:0] grant_clr = grant_go ? (6'd1 << win_idx) : 6'd0;

    // Next request vector: edges set, grant clears, set wins over clear
    wire [5:0] req_sw   = wr_req ? hwdata_i[5:0] : req_q;
    wire [5:0] req_d    = (req_sw & ~grant_clr) | edge_pulse;

    // Sticky event status: grant events; read clears, new event wins
    wire [5:0] stat_d   = (rd_stat ? 6'd0 : stat_q) | grant_clr;

    // Vector address of the winner, first byte then second
    wire [15:0] vec_base = 16'(win_q) * `VEC_STRIDE;

    // Sequencer next state
    always_comb begin
        gs_d = gs_q;
        case (gs_q)
            irq_unit_pkg::GS_IDLE: begin
                if (grant_go) begin
                    gs_d = irq_unit_pkg::GS_PUSH;
                end
            end
            irq_unit_pkg::GS_PUSH: begin
                gs_d = irq_unit_pkg::GS_VLO;
            end
            irq_unit_pkg::GS_VLO: begin
                gs_d = irq_unit_pkg::GS_VHI;
            end
            irq_unit_pkg::GS_VHI: begin
                gs_d = irq_unit_pkg::GS_DONE;
            end
            irq_unit_pkg::GS_DONE: begin
                gs_d = irq_unit_pkg::GS_IDLE;
            end
            default: begin
                gs_d = irq_unit_pkg::GS_IDLE;
            end
        endcase
    end

    // Bus address phase capture
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_idx_q   <= 8'h00;
            hrdata_q   <= 32'h0000_0000;
        end else begin
            ap_valid_q <= ap_take;
            ap_write_q <= hwrite_i;
            ap_idx_q   <= haddr_i[9:2];
            hrdata_q   <= (ap_take & ~hwrite_i & ~unmapped) ? {24'h00_0000, rd_byte}
                                                            : 32'h0000_0000;
        end
    end

    // Software registers and request capture
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prio_q  <= `PRIO_RST;
            mask_q  <= `MASK_RST;
            req_q   <= 6'h00;
            stat_q  <= 6'h00;
            imask_q <= 6'h00;
        end else begin
            if (wr_prio) begin
                prio_q <= hwdata_i[7:0];
            end
            // Grant clears the global enable; a same-cycle write loses
            if (grant_go) begin
                mask_q <= {1'b0, mask_q[6:0]};
            end else if (wr_mask) begin
                mask_q <= hwdata_i[7:0];
            end
            if (wr_imask) begin
                imask_q <= hwdata_i[5:0];
            end
            req_q  <= req_d;
            stat_q <= stat_d;
        end
    end

    // Grant sequencer: push, fetch two vector bytes, load PC
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gs_q    <= irq_unit_pkg::GS_IDLE;
            win_q   <= 3'd0;
            vlo_q   <= 8'h00;
            push_q  <= 1'b0;
            pdata_q <= 24'h00_0000;
            paddr_q <= 16'h0000;
            prd_q   <= 1'b0;
            pcl_q   <= 1'b0;
            pcv_q   <= 16'h0000;
            gie_q   <= 1'b0;
        end else begin
            gs_q   <= gs_d;
            push_q <= grant_go;
            gie_q  <= grant_go;
            pcl_q  <= 1'b0;
            prd_q  <= 1'b0;
            if (grant_go) begin
                win_q   <= win_idx;
                pdata_q <= {pc_i, flags_i};
            end
            case (gs_q)
                irq_unit_pkg::GS_PUSH: begin
                    paddr_q <= vec_base;
                    prd_q   <= 1'b1;
                end
                irq_unit_pkg::GS_VLO: begin
                    paddr_q <= vec_base + 16'h0001;
                    prd_q   <= 1'b1;
                end
                irq_unit_pkg::GS_VHI: begin
                    vlo_q   <= pmem_data_i;                        // First byte is upper half
                end
                irq_unit_pkg::GS_DONE: begin
                    pcv_q   <= {vlo_q, pmem_data_i};
                    pcl_q   <= 1'b1;
                end
                default: begin
                    prd_q   <= 1'b0;
                end
            endcase
        end
    end

    // Core-facing level outputs
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pend_q <= 1'b0;
            wake_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            pend_q <= any_en;
            wake_q <= halted_i & any_en;
            irq_q  <= |(stat_d & imask_q);
        end
    end

    // Output drive, all from flip-flops except the constant hready and response
    assign hrdata_o      = hrdata_q;
    assign hreadyout_o   = 1'b1;   // Zero wait states
    assign hresp_o       = 1'b0;   // Always OKAY
    assign int_pending_o = pend_q;
    assign wake_o        = wake_q;
    assign pmem_addr_o   = paddr_q;
    assign pmem_rd_o     = prd_q;
    assign push_o        = push_q;
    assign push_data_o   = pdata_q;
    assign pc_load_o     = pcl_q;
    assign pc_value_o    = pcv_q;
    assign gie_clr_o     = gie_q;
    assign irq_o         = irq_q;

    // Unused bus inputs
    wire unused_ok = &{1'b0, hsize_i, htrans_i[0]};

endmodule : irq_unit

`default_nettype wire

/* File: testbench/irq_unit_sva.sv */
// Concurrent checks on grant, vector fetch and wake outputs of the interrupt unit.
// Assumes the bind at the foot attaches it to every instance of the unit.
`timescale 1ns/1ps
`default_nettype none

module irq_unit_sva (
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        sys_rst_i,
    // Core side
    input wire logic        int_cycle_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0]  flags_i,
    input wire logic        halted_i,
    input wire logic [7:0]  pmem_data_i,
    input wire logic        int_pending_o,
    input wire logic        wake_o,
    input wire logic [15:0] pmem_addr_o,
    input wire logic        pmem_rd_o,
    input wire logic        push_o,
    input wire logic [23:0] push_data_o,
    input wire logic        pc_load_o,
    input wire logic [15:0] pc_value_o,
    input wire logic        gie_clr_o
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    grant_save_a: assert property (push_o |-> gie_clr_o && push_data_o == {$past(pc_i), $past(flags_i)})
        else $error("grant without enable clear or saved state");
    grant_cause_a: assert property (push_o |-> $past(int_cycle_i))
        else $error("grant without interrupt machine cycle");
    vec_low_a: assert property (push_o |=> pmem_rd_o && !pmem_addr_o[0] && pmem_addr_o <= 16'h000a)
        else $error("first vector byte outside slot table");
    vec_high_a: assert property (push_o ##1 pmem_rd_o |=> pmem_rd_o && pmem_addr_o == $past(pmem_addr_o) + 16'h0001)
        else $error("second vector byte not the following address");
    svc_load_a: assert property (push_o |-> ##4 pc_load_o && pc_value_o == {$past(pmem_data_i, 2), $past(pmem_data_i)})
        else $error("service address not built from the two vector bytes");
    busy_hold_a: assert property (push_o |=> !push_o [*4])
        else $error("second grant while sequencer busy");
    fetch_order_a: assert property (pmem_rd_o |-> $past(push_o) || $past(push_o, 2))
        else $error("vector fetch without preceding save");
    halt_wake_a: assert property (wake_o |-> int_pending_o && $past(halted_i))
        else $error("wake without halt and enabled request");
endmodule : irq_unit_sva

bind irq_unit irq_unit_sva u_sva (.clk_sys_i, .sys_rst_i, .int_cycle_i, .pc_i, .flags_i, .halted_i,
    .pmem_data_i, .int_pending_o, .wake_o, .pmem_addr_o, .pmem_rd_o, .push_o, .push_data_o,
    .pc_load_o, .pc_value_o, .gie_clr_o);

`default_nettype wire

/* File: testbench/irq_far_side.sv */
// Far-side model: port pins, timer terminal events and the vector bytes of program memory.
// Assumes fire() is called by one bench process at a time.
`timescale 1ns/1ps
`default_nettype none

module irq_far_side (
    // Clock
    input  wire logic        clk_sys_i,
    // Vector fetch
    input  wire logic        pmem_rd_i,
    input  wire logic [15:0] pmem_addr_i,
    output var  logic [7:0]  pmem_data_o,
    // Pins and timer events
    output var  logic        pin1_o,
    output var  logic        pin2_o,
    output var  logic        pin3_o,
    output var  logic        tmr0_o,
    output var  logic        tmr1_o
);
    // Pins idle high, timers quiet
    initial begin
        pin1_o = 1'b1;
        pin2_o = 1'b1;
        pin3_o = 1'b1;
        tmr0_o = 1'b0;
        tmr1_o = 1'b0;
        pmem_data_o = 8'h00;
    end

    // Slot byte one cycle after the read; an idle bus flips so stale data never matches
    always @(posedge clk_sys_i) begin
        pmem_data_o <= pmem_rd_i ? 8'h30 + pmem_addr_i[7:0] : ~pmem_data_o;
    end

    // One event of source s; the shared pin stays where it went so its other edge is free
    task automatic fire(input int s);
        @(posedge clk_sys_i);
        case (s)
            0: pin2_o <= 1'b0;
            1: pin3_o <= 1'b0;
            2: pin1_o <= 1'b0;
            3: pin2_o <= 1'b1;
            4: tmr0_o <= 1'b1;
            default: tmr1_o <= 1'b1;
        endcase
        @(posedge clk_sys_i);
        pin1_o <= 1'b1;
        pin3_o <= 1'b1;
        tmr0_o <= 1'b0;
        tmr1_o <= 1'b0;
    endtask : fire
endmodule : irq_far_side

`default_nettype wire

/* File: testbench/test_six_source_vectored_interrupt_unit.sv */
// Self-checking bench: registers over AHB-Lite, request recording, enables, grants.
// Assumes the far-side model supplies pins, timer events and vector bytes.
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_regs.svh"

module test_six_source_vectored_interrupt_unit;
    localparam logic [31:0] A_PRIO  = `ADDR_OF(`PRIO_IDX);
    localparam logic [31:0] A_REQ   = `ADDR_OF(`REQ_IDX);
    localparam logic [31:0] A_MASK  = `ADDR_OF(`MASK_IDX);
    localparam logic [31:0] A_STAT  = `ADDR_OF(`STAT_IDX);
    localparam logic [31:0] A_IMASK = `ADDR_OF(`IMASK_IDX);
    localparam logic [31:0] ZERO    = 32'h0000_0000;
    localparam logic [23:0] MSK     = 24'h3f_be81; // Global off, own bit off, both on

    logic        clk_sys_i = 1'b0, sys_rst_i = 1'b1;     // Clock and reset
    logic        hsel_i = 1'b1, hwrite_i = 1'b0;         // Bus request
    logic [1:0]  htrans_i = 2'b00;
    logic [2:0]  hsize_i = 3'b010;
    logic [31:0] haddr_i = ZERO, hwdata_i = ZERO, hrdata_o, rd_q;
    logic        hreadyout_o, hresp_o, rdy_q;
    wire  logic  hready_i = hreadyout_o;                 // Single slave drives hready
    logic        port3_pin1_i, port3_pin2_i, port3_pin3_i;
    logic        counter_timer_zero_i, counter_timer_one_i;
    logic        int_cycle_i = 1'b0, halted_i = 1'b0;    // Core side
    logic [15:0] pc_i = 16'h0000, pmem_addr_o, pc_value_o;
    logic [7:0]  flags_i = 8'h00, pmem_data_i;
    logic [23:0] push_data_o;
    logic        int_pending_o, wake_o, pmem_rd_o, push_o, pc_load_o, gie_clr_o, irq_o;
    int          num_errors = 0, samples_checked = 0;

    irq_unit DUT (.clk_sys_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
        .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .port3_pin1_i, .port3_pin2_i,
        .port3_pin3_i, .counter_timer_zero_i, .counter_timer_one_i, .int_cycle_i, .pc_i,
        .flags_i, .halted_i, .pmem_data_i, .int_pending_o, .wake_o, .pmem_addr_o, .pmem_rd_o,
        .push_o, .push_data_o, .pc_load_o, .pc_value_o, .gie_clr_o, .irq_o);
    irq_far_side u_far (.clk_sys_i, .pmem_rd_i(pmem_rd_o), .pmem_addr_i(pmem_addr_o),
        .pmem_data_o(pmem_data_i), .pin1_o(port3_pin1_i), .pin2_o(port3_pin2_i),
        .pin3_o(port3_pin3_i), .tmr0_o(counter_timer_zero_i), .tmr1_o(counter_timer_one_i));

    // 4 ns period
    always #2 clk_sys_i = ~clk_sys_i;

    // Edge samples of the answer, read just after the edge to avoid races
    always @(posedge clk_sys_i) begin
        rd_q <= hrdata_o;
        rdy_q <= hready_i;
    end

    // Expected service address: vector bytes of slot s, upper byte first
    function automatic logic [15:0] vec_exp(input int s);
        return {8'h30 + 8'(2 * s), 8'h31 + 8'(2 * s)};
    endfunction : vec_exp

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : settle

    // Holds the current phase until hready is seen high at an edge
    task automatic wait_rdy();
        do begin
            @(posedge clk_sys_i);
            #1;
        end while (rdy_q !== 1'b1);
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_sys_i);
        htrans_i <= 2'b10;
        haddr_i <= a;
        hwrite_i <= wr;
        wait_rdy();
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        wait_rdy();
        rd = rd_q;
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask : wr

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, ZERO, v);
        chk_word(v, exp);
        chk_bit(hresp_o, 1'b0);
    endtask : rchk

    task automatic print_verdict();
        $display("checked %0d samples, %0d errors", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // Whole run takes well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        num_errors++;
        print_verdict();
    end

    initial begin
        logic [31:0] v;
        logic [5:0]  pat;
        void'($urandom(40515));
        repeat (6) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rchk(A_PRIO, ZERO);
        rchk(A_REQ, ZERO);
        rchk(A_MASK, ZERO);
        wr(ZERO, 32'hffff_ffff);
        rchk(ZERO, ZERO);
        v = $urandom;
        wr(A_PRIO, v);
        rchk(A_PRIO, v & 32'h0000_00ff);
        $display("test registers done");
        // Every source recorded while all are masked
        wr(A_MASK, ZERO);
        for (int s = 0; s < 6; s++) begin
            u_far.fire(s);
            rchk(A_REQ, 32'h1 << s);
            chk_bit(int_pending_o, 1'b0);
            wr(A_REQ, ZERO);
        end
        $display("test recording done");
        // Global and own enable both needed; halted core is woken
        wr(A_REQ, 32'h0000_0001);
        for (int k = 0; k < 3; k++) begin
            wr(A_MASK, {24'h0, MSK[8 * (2 - k) +: 8]});
            settle(3);
            chk_bit(int_pending_o, k == 2);
        end
        @(posedge clk_sys_i);
        halted_i <= 1'b1;
        settle(3);
        chk_bit(wake_o, 1'b1);
        @(posedge clk_sys_i);
        halted_i <= 1'b0;
        $display("test enables done");
        // Grant each source against random rivals, both priority directions
        wr(A_IMASK, 32'h0000_003e);
        for (int s = 0; s < 6; s++) begin
            pat = 6'($urandom) | 6'(1 << s);
            wr(A_REQ, {26'h0, pat});
            wr(A_PRIO, 32'(s + 8 * (s % 2)));
            wr(A_MASK, 32'h0000_00bf);
            @(posedge clk_sys_i);
            pc_i <= 16'($urandom);
            flags_i <= 8'($urandom);
            int_cycle_i <= 1'b1;
            for (int n = 0; n < 20 && push_o !== 1'b1; n++) @(negedge clk_sys_i);
            chk_bit(gie_clr_o, 1'b1);
            chk_word({8'h0, push_data_o}, {8'h0, pc_i, flags_i});
            int_cycle_i <= 1'b0;
            for (int n = 0; n < 20 && pc_load_o !== 1'b1; n++) @(negedge clk_sys_i);
            chk_word({16'h0, pc_value_o}, {16'h0, vec_exp(s)});
            chk_bit(irq_o, s != 0);
            rchk(A_REQ, {26'h0, pat & ~6'(1 << s)});
            rchk(A_MASK, 32'h0000_003f);
            rchk(A_STAT, 32'h1 << s);
            settle(2);
            chk_bit(irq_o, 1'b0);
        end
        $display("test grants done");
        print_verdict();
    end
endmodule : test_six_source_vectored_interrupt_unit

`default_nettype wire
